//--- rtl/synth_spread_spectrum_modulator.sv
`timescale 1ns/1ps
// What this block does
// RULE1: Each modulation cycle starts at nominal frequency
// RULE2: Centre: down half, up full, back
// RULE3: Down: down full spread, back up
// RULE4: Cycle period from 16-bit period setting
// RULE5: Deviation counts are 0.025 percent steps
// RULE6: Software writes deviation only 1 to 200; the register takes any byte 0 to 255 unchecked
// RULE7: Sweep repeats back to back at nominal
module synth_spread_spectrum_modulator (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Register port
   input wire ssm_pkg::reg_req_t regReq,
   output logic [7:0] regRdata,
   // Modulation output
   output logic signed [ssm_pkg::ACC_W-1:0] freqOffset,
   output logic [15:0] offsetScale,
   output logic modActive
);
   import ssm_pkg::*;

   ssm_state_t s_r;
   ssm_state_t s_nxt;
   logic tick;
   logic run;
   logic lastStep;
   logic sweepDown;
   logic signed [ACC_W-1:0] stepv;
   logic signed [ACC_W-1:0] centreFloor;
   logic signed [ACC_W-1:0] downFloor;

   function automatic logic [7:0] read_reg(input ssm_state_t st, input logic [15:0] a);
      logic [7:0] d;
      d = UNMAPPED_READ;
      case (a)
         SWEEP_PROFILE_CFG_ADDR: d = {7'h00, st.cfgMode};
         MOD_PERIOD_HI_ADDR: d = st.period[15:8];
         MOD_PERIOD_LO_ADDR: d = st.period[7:0];
         PEAK_DEVIATION_ADDR: d = st.dev;
         default: d = UNMAPPED_READ;
      endcase
      return d;
   endfunction

   // Direction of the step taken from tick index t to t+1
   function automatic logic step_down(input profile_t m, input logic [15:0] per,
                                      input logic [15:0] t);
      logic d;
      d = 1'b0;
      case (m)
         CENTRE_PROFILE: d = (t < (per >> 2)) || (t >= (per - (per >> 2)));
         DOWN_PROFILE: d = (t < (per >> 1));
         default: d = 1'b0;
      endcase
      return d;
   endfunction

   // Deviation times period, the accumulator depth of a full-spread leg
   function automatic logic [ACC_W-1:0] spread_span(input logic [7:0] d,
                                                    input logic [15:0] p);
      return ACC_W'(d) * ACC_W'(p);
   endfunction

   always_comb begin
      tick = (s_r.div == TICK_LAST);
      run = (s_r.period != 16'h0000) && (s_r.dev != 8'h00);
      lastStep = (s_r.t == s_r.lPer - 16'h0001);
      // Slope is 2*dev per tick so each leg spans the documented spread
      stepv = signed'(ACC_W'({s_r.lDev, 1'b0})); // RULE5
      sweepDown = step_down(s_r.lMode, s_r.lPer, s_r.t); // RULE2 RULE3
      centreFloor = -signed'(spread_span(s_r.lDev, s_r.lPer) >> 1) - stepv;
      downFloor = -signed'(spread_span(s_r.lDev, s_r.lPer)) - stepv;
   end

   always_comb begin
      s_nxt = s_r;
      if (regReq.rd) begin
         s_nxt.rdData = read_reg(s_r, regReq.addr);
      end
      if (regReq.wr) begin
         case (regReq.addr)
            SWEEP_PROFILE_CFG_ADDR: s_nxt.cfgMode = profile_t'(regReq.wdata[PROFILE_BIT]);
            MOD_PERIOD_HI_ADDR: s_nxt.period[15:8] = regReq.wdata; // RULE4
            MOD_PERIOD_LO_ADDR: s_nxt.period[7:0] = regReq.wdata; // RULE4
            PEAK_DEVIATION_ADDR: s_nxt.dev = regReq.wdata;
            default: s_nxt.period = s_r.period;
         endcase
      end
      s_nxt.div = tick ? 8'h00 : s_r.div + 8'h01;
      if (tick) begin
         if (!s_r.active || lastStep) begin
            // New cycle: settings latched, frequency held at nominal
            s_nxt.active = run;
            s_nxt.lMode = s_r.cfgMode;
            s_nxt.lPer = s_r.period; // RULE4
            s_nxt.lDev = s_r.dev;
            s_nxt.t = 16'h0000;
            s_nxt.acc = '0; // RULE1 RULE7
         end else begin
            s_nxt.t = s_r.t + 16'h0001;
            s_nxt.acc = sweepDown ? s_r.acc - stepv : s_r.acc + stepv; // RULE2 RULE3
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s_r <= '{cfgMode: profile_t'(SWEEP_PROFILE_CFG_RST[PROFILE_BIT]),
                  period: MOD_PERIOD_RST, dev: PEAK_DEVIATION_RST,
                  lMode: CENTRE_PROFILE, lPer: 16'h0000, lDev: 8'h00, active: 1'b0,
                  div: 8'h00, t: 16'h0000, acc: '0, rdData: 8'h00};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign regRdata = s_r.rdData;
   assign freqOffset = s_r.acc;
   assign offsetScale = s_r.lPer;
   assign modActive = s_r.active;

   sequence s_cycle_start;
      s_r.active && tick && (s_r.t == 16'h0000) && (s_r.lPer >= 16'h0004);
   endsequence

   sequence s_first_step_down;
      (s_r.acc == -stepv) && (s_r.t == 16'h0001);
   endsequence

   property p_start_nominal;
      @(posedge sys_clk) disable iff (!nrst)
      $rose(s_r.active) |-> (s_r.acc == '0) && (s_r.t == 16'h0000);
   endproperty
   a_start_nominal: assert property (p_start_nominal) // RULE1
      else $error("modulation did not start at nominal");

   property p_centre_first_dip;
      @(posedge sys_clk) disable iff (!nrst)
      s_cycle_start ##0 (s_r.lMode == CENTRE_PROFILE) |=> s_first_step_down;
   endproperty
   a_centre_first_dip: assert property (p_centre_first_dip) // RULE2
      else $error("centre sweep did not start downward");

   property p_centre_floor;
      @(posedge sys_clk) disable iff (!nrst)
      s_r.active && (s_r.lMode == CENTRE_PROFILE) |-> s_r.acc >= centreFloor;
   endproperty
   a_centre_floor: assert property (p_centre_floor) // RULE2
      else $error("centre sweep went below half spread");

   property p_down_below_nominal;
      @(posedge sys_clk) disable iff (!nrst)
      s_r.active && (s_r.lMode == DOWN_PROFILE) |-> s_r.acc <= 0;
   endproperty
   a_down_below_nominal: assert property (p_down_below_nominal) // RULE3
      else $error("down sweep rose above nominal");

   property p_down_first_dip;
      @(posedge sys_clk) disable iff (!nrst)
      s_cycle_start ##0 (s_r.lMode == DOWN_PROFILE) |=> s_first_step_down;
   endproperty
   a_down_first_dip: assert property (p_down_first_dip) // RULE3
      else $error("down sweep did not start downward");

   property p_period_bound;
      @(posedge sys_clk) disable iff (!nrst)
      s_r.active |-> s_r.t < s_r.lPer;
   endproperty
   a_period_bound: assert property (p_period_bound) // RULE4
      else $error("tick index passed the period");

   property p_slope;
      @(posedge sys_clk) disable iff (!nrst)
      s_r.active && tick && !lastStep |=>
         (s_r.acc == $past(s_r.acc) + $past(stepv)) ||
         (s_r.acc == $past(s_r.acc) - $past(stepv));
   endproperty
   a_slope: assert property (p_slope) // RULE5
      else $error("sweep step is not twice the deviation");

   property p_wrap;
      @(posedge sys_clk) disable iff (!nrst)
      s_r.active && tick && lastStep && run |=>
         s_r.active && (s_r.t == 16'h0000) && (s_r.acc == '0);
   endproperty
   a_wrap: assert property (p_wrap) // RULE7
      else $error("cycle did not wrap back to nominal");

   property p_idle_nominal;
      @(posedge sys_clk) disable iff (!nrst)
      !s_r.active |-> s_r.acc == '0;
   endproperty
   a_idle_nominal: assert property (p_idle_nominal) // RULE1
      else $error("idle modulator left nominal frequency");

   property p_down_floor;
      @(posedge sys_clk) disable iff (!nrst)
      s_r.active && (s_r.lMode == DOWN_PROFILE) |-> s_r.acc >= downFloor;
   endproperty
   a_down_floor: assert property (p_down_floor) // RULE3
      else $error("down sweep went below full spread");

   property p_latch_start;
      @(posedge sys_clk) disable iff (!nrst)
      $rose(s_r.active) |-> (s_r.lPer == $past(s_r.period)) &&
         (s_r.lDev == $past(s_r.dev)) && (s_r.lMode == $past(s_r.cfgMode));
   endproperty
   a_latch_start: assert property (p_latch_start) // RULE4
      else $error("cycle settings not taken at start");

   property p_latch_held;
      @(posedge sys_clk) disable iff (!nrst)
      s_r.active && !(tick && lastStep) |=>
         $stable(s_r.lPer) && $stable(s_r.lDev) && $stable(s_r.lMode);
   endproperty
   a_latch_held: assert property (p_latch_held) // RULE4
      else $error("cycle settings changed inside a cycle");

   property p_tick_restart;
      @(posedge sys_clk) disable iff (!nrst)
      tick |=> s_r.div == 8'h00;
   endproperty
   a_tick_restart: assert property (p_tick_restart) // RULE4
      else $error("tick divider did not restart");

   property p_offset_steady;
      @(posedge sys_clk) disable iff (!nrst)
      !tick |=> $stable(s_r.acc);
   endproperty
   a_offset_steady: assert property (p_offset_steady) // RULE5
      else $error("offset moved between ticks");
endmodule

//--- rtl/ssm_pkg.sv
package ssm_pkg;
   // Byte offsets of the modulator registers
   localparam logic [15:0] SWEEP_PROFILE_CFG_ADDR = 16'h0694;
   localparam logic [15:0] MOD_PERIOD_HI_ADDR = 16'h0695;
   localparam logic [15:0] MOD_PERIOD_LO_ADDR = 16'h0696;
   localparam logic [15:0] PEAK_DEVIATION_ADDR = 16'h0697;
   // Field positions and reset values
   localparam int PROFILE_BIT = 0;
   localparam logic [7:0] SWEEP_PROFILE_CFG_RST = 8'h00;
   localparam logic [15:0] MOD_PERIOD_RST = 16'h0000;
   localparam logic [7:0] PEAK_DEVIATION_RST = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // Modulation tick: 125 MHz / 125 = 1 us per period count
   localparam int TICK_DIV = 125;
   localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);
   localparam int ACC_W = 26;

   typedef enum logic {CENTRE_PROFILE, DOWN_PROFILE} profile_t;

   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      profile_t cfgMode;
      logic [15:0] period;
      logic [7:0] dev;
      profile_t lMode;
      logic [15:0] lPer;
      logic [7:0] lDev;
      logic active;
      logic [7:0] div;
      logic [15:0] t;
      logic signed [ACC_W-1:0] acc;
      logic [7:0] rdData;
   } ssm_state_t;
endpackage

//--- tb/test_synth_spread_spectrum_modulator.sv
`timescale 1ns/1ps
module test_synth_spread_spectrum_modulator;
   import ssm_pkg::*;
   typedef struct packed {logic [15:0] a; logic w; logic [7:0] d; logic [7:0] e;} row_t;
   logic sys_clk;
   logic nrst;
   reg_req_t regReq;
   logic [7:0] regRdata;
   logic signed [ACC_W-1:0] freqOffset;
   logic [15:0] offsetScale;
   logic modActive;
   int error_cnt = 0;
   int checks = 0;
   // Address, write flag, write byte, expected read
   row_t rows [13] = '{'{16'h0694, 1'b0, 8'h00, 8'h00}, '{16'h0695, 1'b0, 8'h00, 8'h00},
      '{16'h0696, 1'b0, 8'h00, 8'h00}, '{16'h0697, 1'b0, 8'h00, 8'h00},
      '{16'h0694, 1'b1, 8'hff, 8'h01}, '{16'h0697, 1'b1, 8'hc8, 8'hc8},
      '{16'h0697, 1'b1, 8'h01, 8'h01}, '{16'h0695, 1'b1, 8'ha5, 8'ha5},
      '{16'h0696, 1'b1, 8'h3c, 8'h3c}, '{16'h0700, 1'b1, 8'h55, 8'h00},
      '{16'h0695, 1'b1, 8'h00, 8'h00}, '{16'h0696, 1'b1, 8'h08, 8'h08},
      '{16'h0694, 1'b1, 8'h00, 8'h00}};
   // Two centre cycles, one down cycle, then nominal
   int expOff [25] = '{0, -8, -16, -8, 0, 8, 16, 8, 0, -8, -16, -8, 0, 8, 16, 8,
      0, -8, -16, -24, -32, -24, -16, -8, 0};

   synth_spread_spectrum_modulator synth_spread_spectrum_modulator_i (
      .sys_clk(sys_clk), .nrst(nrst), .regReq(regReq), .regRdata(regRdata),
      .freqOffset(freqOffset), .offsetScale(offsetScale), .modActive(modActive));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (e !== s) begin
         $display("BAD %s expected %h seen %h", n, e, s);
         error_cnt++;
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regReq <= '{a, 1'b1, 1'b0, d};
      @(posedge sys_clk);
      regReq.wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      regReq <= '{a, 1'b0, 1'b1, 8'h00};
      @(posedge sys_clk);
      regReq.rd <= 1'b0;
      @(negedge sys_clk);
      chk("regRdata", {24'h0, e}, {24'h0, regRdata});
   endtask

   task automatic finish_test;
      if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      finish_test();
   end

   initial begin
      nrst = 1'b0;
      regReq = '0;
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      wr(PEAK_DEVIATION_ADDR, 8'h04);
      for (int n = 0; n < 300 && modActive !== 1'b1; n++) @(negedge sys_clk);
      chk("modActive", 32'h1, {31'h0, modActive});
      repeat (60) @(posedge sys_clk);
      for (int k = 0; k < 25; k++) begin
         chk("freqOffset", expOff[k], freqOffset);
         chk("offsetScale", 32'h8, {16'h0, offsetScale});
         if (k == 9) wr(SWEEP_PROFILE_CFG_ADDR, 8'h01);
         repeat (k == 9 ? 123 : 125) @(posedge sys_clk);
      end
      // Zero period stops at the end of the running cycle
      wr(MOD_PERIOD_LO_ADDR, 8'h00);
      for (int n = 0; n < 1300 && modActive !== 1'b0; n++) @(negedge sys_clk);
      chk("modActive", 32'h0, {31'h0, modActive});
      chk("freqOffset", 32'h0, freqOffset);
      // Reset in mid-run
      wr(MOD_PERIOD_LO_ADDR, 8'h08);
      repeat (400) @(posedge sys_clk);
      chk("modActive", 32'h1, {31'h0, modActive});
      nrst <= 1'b0;
      @(negedge sys_clk);
      chk("modActive", 32'h0, {31'h0, modActive});
      chk("freqOffset", 32'h0, freqOffset);
      chk("offsetScale", 32'h0, {16'h0, offsetScale});
      @(posedge sys_clk);
      nrst <= 1'b1;
      rd(PEAK_DEVIATION_ADDR, 8'h00);
      rd(MOD_PERIOD_LO_ADDR, 8'h00);
      finish_test();
   end
endmodule
